// ---- design/sdmb_pkg.sv ----
// sdmb_pkg: constants, command codes, mode layout and bus carriers
// for the dram mode and burst control block.
// assumes a single 10 MHz system clock.
package sdmb_pkg;
  localparam int CLK_PERIOD_NS = 100;
  // write recovery time in ns
  localparam int WRITE_RECOVERY_NS = 15;
  localparam int WR_CYC_RAW =
    (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_CYC = (WR_CYC_RAW < 1) ? 1 : WR_CYC_RAW;

  localparam int NUM_BANKS = 4;
  localparam int NUM_BYTES = 4;
  localparam int COL_W = 8;
  localparam int IDX_W = 9;
  localparam int CNT_W = 4;
  localparam int AP_BIT = 10;

  // {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_MODE = 3'h0;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_STOP = 3'h6;

  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [8:0] LEN_1 = 9'h001;
  localparam logic [8:0] LEN_2 = 9'h002;
  localparam logic [8:0] LEN_4 = 9'h004;
  localparam logic [8:0] LEN_8 = 9'h008;
  localparam logic [8:0] LEN_PAGE = 9'h100;
  localparam logic [2:0] CL_2 = 3'h2;
  localparam logic [2:0] CL_3 = 3'h3;

  // register map (byte addresses)
  localparam int AXI_AW = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RECOV = 4'h8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0001;
  localparam int CTRL_DEC_EN = 0;
  localparam int ST_LOADED = 16;
  localparam int ST_ACTIVE = 17;
  localparam int ST_READ = 18;
  localparam int ST_AP = 19;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum {OP_NONE, OP_MODE, OP_RD, OP_WR, OP_STOP, OP_PRE} sdmb_op_t;
  typedef enum {ST_IDLE, ST_RDB, ST_WRB} sdmb_state_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bank_select;
    logic [10:0] addr;
  } sdmb_cmd_t;

  typedef struct packed {
    logic [2:0] reserved_bits;
    logic write_burst_length_select;
    logic [1:0] test_mode;
    logic [2:0] latency;
    logic burst_order_select;
    logic [2:0] burst_length;
  } sdmb_mode_t;

  typedef struct packed {
    logic awvalid;
    logic [3:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [3:0] araddr;
    logic rready;
  } sdmb_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sdmb_axi_rsp_t;
endpackage

// ---- design/sdmb_axil.sv ----
// sdmb_axil: axi4-lite slave with control, status and recovery words.
// assumes one write and one read at most in flight from the master.
`timescale 1ns/100ps
module sdmb_axil (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire sdmb_pkg::sdmb_axi_req_t axi_req,
  output sdmb_pkg::sdmb_axi_rsp_t axi_rsp,
  output logic [31:0] ctrl_word,
  input wire logic [31:0] status_word,
  input wire logic [31:0] recov_word
);
  import sdmb_pkg::*;

  logic aw_held, w_held, bvalid, rvalid;
  logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
  logic [AXI_AW-1:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data, rdata, next_rdata, next_ctrl_word;
  logic [3:0] w_strb, next_w_strb;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;

  function automatic logic [AXI_AW-1:0] word_of(input logic [AXI_AW-1:0] a);
    word_of = {a[AXI_AW-1:2], 2'h0};
  endfunction

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_ctrl_word = ctrl_word;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (bvalid && axi_req.bready) next_bvalid = 1'b0;
    if (axi_req.awvalid && !aw_held && !bvalid) begin
      next_aw_held = 1'b1;
      next_aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !w_held && !bvalid) begin
      next_w_held = 1'b1;
      next_w_data = axi_req.wdata;
      next_w_strb = axi_req.wstrb;
    end
    if (next_aw_held && next_w_held) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OK;
      case (word_of(next_aw_addr))
        REG_CTRL: begin
          if (next_w_strb[0]) next_ctrl_word = next_w_data & CTRL_MASK;
        end
        REG_STATUS, REG_RECOV: ;
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    if (rvalid && axi_req.rready) next_rvalid = 1'b0;
    if (axi_req.arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OK;
      case (word_of(axi_req.araddr))
        REG_CTRL: next_rdata = ctrl_word;
        REG_STATUS: next_rdata = status_word;
        REG_RECOV: next_rdata = recov_word;
        default: begin
          next_rdata = '0;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OK;
      ctrl_word <= CTRL_RESET;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OK;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      ctrl_word <= next_ctrl_word;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  assign axi_rsp.awready = !aw_held && !bvalid;
  assign axi_rsp.wready = !w_held && !bvalid;
  assign axi_rsp.bvalid = bvalid;
  assign axi_rsp.bresp = bresp;
  assign axi_rsp.arready = !rvalid;
  assign axi_rsp.rvalid = rvalid;
  assign axi_rsp.rdata = rdata;
  assign axi_rsp.rresp = rresp;
endmodule

// ---- design/sdmb_ctrl.sv ----
// sdmb_ctrl: command decode, mode register, burst column sequencing
// and bank precharge timing, including concurrent auto precharge.
// assumes commands and byte masks are synchronous to clk_sys.
`timescale 1ns/100ps
// Contract
// - other-bank access accepted during auto precharge
// - read cuts auto-precharged read, precharge now
// - write cuts auto-precharged read, precharge now
// - read cuts auto-precharged write, recovery then precharge
// - write cuts auto-precharged write, recovery then precharge
// - mode set loads bank select and address
// - mode write completes in one cycle
// - low mode bits select burst length
// - mode bit three selects address order
// - sequential order wraps within 256 columns
// - interleaved order inverts start bits by index
// - latency field sets read data delay
// - write burst select makes single-word writes
// - no-operation registers no command
// - burst stop ends non-auto-precharge bursts
// - deselect ignores all command inputs
module sdmb_ctrl #(
  parameter int WR_CYCLES = sdmb_pkg::WR_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire sdmb_pkg::sdmb_cmd_t cmd,
  input wire logic [3:0] dqm,
  input wire sdmb_pkg::sdmb_axi_req_t axi_req,
  output sdmb_pkg::sdmb_axi_rsp_t axi_rsp,
  output sdmb_pkg::sdmb_mode_t mode,
  output logic mode_loaded,
  output logic [7:0] col_addr,
  output logic [1:0] col_bank,
  output logic col_rd,
  output logic col_wr,
  output logic [3:0] wr_byte_en,
  output logic rd_data_valid,
  output logic [3:0] rd_byte_en,
  output logic [3:0] precharge_start
);
  import sdmb_pkg::*;

  if (WR_CYCLES < 1 || WR_CYCLES >= (1 << CNT_W)) begin : g_bad_wr
    $error("WR_CYCLES out of range");
  end

  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] REC_FULL = CNT_W'(WR_CYCLES);
  localparam logic [CNT_W-1:0] REC_LESS = CNT_W'(WR_CYCLES - 1);
  localparam logic [NUM_BANKS-1:0] BANK_ONE = NUM_BANKS'(1);

  sdmb_state_t state, next_state;
  sdmb_op_t op;
  sdmb_mode_t next_mode;
  logic [1:0] b_bank, next_bank, next_col_bank;
  logic [COL_W-1:0] b_start, next_start, next_col_addr;
  logic [IDX_W-1:0] b_idx, next_idx, b_len, next_len, bl_len;
  logic b_full, next_full, b_ap, next_ap, cont_ok;
  logic next_col_rd, next_col_wr, col_cont, next_cont, next_loaded;
  logic [NUM_BYTES-1:0] next_wr_be, dqm_d1;
  logic [NUM_BANKS-1:0] next_pre, pre_banks;
  logic [NUM_BANKS-1:0][CNT_W-1:0] rec_cnt, next_rec;
  logic rd_pipe0;
  logic [31:0] ctrl_word, status_word, recov_word;

  function automatic sdmb_op_t decode_op(input sdmb_cmd_t c, input logic en);
    decode_op = OP_NONE;
    if (en && !c.cs_n) begin
      case ({c.ras_n, c.cas_n, c.we_n})
        CMD_MODE: decode_op = OP_MODE;
        CMD_PRE: decode_op = OP_PRE;
        CMD_WR: decode_op = OP_WR;
        CMD_RD: decode_op = OP_RD;
        CMD_STOP: decode_op = OP_STOP;
        default: decode_op = OP_NONE;
      endcase
    end
  endfunction

  function automatic logic [IDX_W-1:0] len_of(input logic [2:0] code);
    case (code)
      BL_2: len_of = LEN_2;
      BL_4: len_of = LEN_4;
      BL_8: len_of = LEN_8;
      BL_FULL: len_of = LEN_PAGE;
      default: len_of = LEN_1;
    endcase
  endfunction

  function automatic logic [COL_W-1:0] col_of(input logic [COL_W-1:0] s,
      input logic [IDX_W-1:0] k, input logic il);
    if (il) col_of = s ^ k[COL_W-1:0];
    else col_of = COL_W'(s + k[COL_W-1:0]);
  endfunction

  sdmb_axil u_axil (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .axi_req(axi_req),
    .axi_rsp(axi_rsp),
    .ctrl_word(ctrl_word),
    .status_word(status_word),
    .recov_word(recov_word)
  );

  assign op = decode_op(cmd, ctrl_word[CTRL_DEC_EN]);
  assign bl_len = len_of(mode.burst_length);
  assign cont_ok = (state != ST_IDLE) && (b_full || (b_idx + LEN_1) != b_len);
  assign pre_banks = cmd.addr[AP_BIT] ? '1 : (BANK_ONE << cmd.bank_select);

  always_comb begin
    status_word = '0;
    status_word[$bits(sdmb_mode_t)-1:0] = mode;
    status_word[ST_LOADED] = mode_loaded;
    status_word[ST_ACTIVE] = state != ST_IDLE;
    status_word[ST_READ] = state == ST_RDB;
    status_word[ST_AP] = b_ap;
    recov_word = '0;
    for (int b = 0; b < NUM_BANKS; b++) recov_word[b] = rec_cnt[b] != '0;
  end

  always_comb begin
    next_state = state;
    next_bank = b_bank;
    next_start = b_start;
    next_idx = b_idx;
    next_len = b_len;
    next_full = b_full;
    next_ap = b_ap;
    next_col_addr = col_addr;
    next_col_bank = col_bank;
    next_col_rd = 1'b0;
    next_col_wr = 1'b0;
    next_cont = 1'b0;
    next_wr_be = ~dqm;
    next_mode = mode;
    next_loaded = mode_loaded;
    next_pre = '0;
    for (int b = 0; b < NUM_BANKS; b++) begin
      next_rec[b] = rec_cnt[b];
      if (rec_cnt[b] != '0) begin
        next_rec[b] = rec_cnt[b] - CNT_ONE;
        if (rec_cnt[b] == CNT_ONE) next_pre[b] = 1'b1;
      end
    end
    if (cont_ok) begin
      next_idx = b_full ? {1'b0, b_idx[COL_W-1:0] + 8'h01} : b_idx + LEN_1;
      next_col_addr = col_of(b_start, next_idx,
          mode.burst_order_select && !b_full);
      next_col_rd = state == ST_RDB;
      next_col_wr = state == ST_WRB;
      next_cont = 1'b1;
    end else if (state != ST_IDLE) begin
      next_state = ST_IDLE;
      if (b_ap) begin
        if (state == ST_RDB || WR_CYCLES == 1) next_pre[b_bank] = 1'b1;
        else next_rec[b_bank] = REC_LESS;
      end
    end
    case (op)
      OP_MODE: begin
        next_mode = {cmd.bank_select, cmd.addr};
        next_loaded = 1'b1;
      end
      OP_RD, OP_WR: begin
        if (cont_ok && b_ap && cmd.bank_select != b_bank) begin
          if (state == ST_RDB) next_pre[b_bank] = 1'b1;
          else next_rec[b_bank] = REC_FULL;
        end
        next_state = (op == OP_RD) ? ST_RDB : ST_WRB;
        next_bank = cmd.bank_select;
        next_start = cmd.addr[COL_W-1:0];
        next_idx = '0;
        next_ap = cmd.addr[AP_BIT];
        next_full = mode.burst_length == BL_FULL;
        next_len = bl_len;
        if (op == OP_WR && mode.write_burst_length_select) begin
          next_full = 1'b0;
          next_len = LEN_1;
        end
        next_col_addr = cmd.addr[COL_W-1:0];
        next_col_bank = cmd.bank_select;
        next_col_rd = op == OP_RD;
        next_col_wr = op == OP_WR;
        next_cont = 1'b0;
      end
      OP_STOP: begin
        if (state != ST_IDLE && !b_ap) begin
          next_state = ST_IDLE;
          next_col_rd = 1'b0;
          next_col_wr = 1'b0;
          next_cont = 1'b0;
        end
      end
      OP_PRE: begin
        next_pre = next_pre | pre_banks;
        if (state != ST_IDLE && !b_ap && pre_banks[b_bank]) begin
          next_state = ST_IDLE;
          next_col_rd = 1'b0;
          next_col_wr = 1'b0;
          next_cont = 1'b0;
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      b_bank <= '0;
      b_start <= '0;
      b_idx <= '0;
      b_len <= '0;
      b_full <= 1'b0;
      b_ap <= 1'b0;
      col_addr <= '0;
      col_bank <= '0;
      col_rd <= 1'b0;
      col_wr <= 1'b0;
      col_cont <= 1'b0;
      wr_byte_en <= '0;
      mode <= '0;
      mode_loaded <= 1'b0;
      precharge_start <= '0;
      rec_cnt <= '0;
    end else begin
      state <= next_state;
      b_bank <= next_bank;
      b_start <= next_start;
      b_idx <= next_idx;
      b_len <= next_len;
      b_full <= next_full;
      b_ap <= next_ap;
      col_addr <= next_col_addr;
      col_bank <= next_col_bank;
      col_rd <= next_col_rd;
      col_wr <= next_col_wr;
      col_cont <= next_cont;
      wr_byte_en <= next_wr_be;
      mode <= next_mode;
      mode_loaded <= next_loaded;
      precharge_start <= next_pre;
      rec_cnt <= next_rec;
    end
  end

  // read data timing; output enables follow the mask two clocks late
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_pipe0 <= 1'b0;
      rd_data_valid <= 1'b0;
      dqm_d1 <= '0;
      rd_byte_en <= '0;
    end else begin
      rd_pipe0 <= col_rd;
      rd_data_valid <= (mode.latency == CL_2) ? col_rd : rd_pipe0;
      dqm_d1 <= dqm;
      rd_byte_en <= ~dqm_d1;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  sequence s_ap_rd_busy;
    cont_ok && b_ap && state == ST_RDB;
  endsequence
  sequence s_ap_wr_busy;
    cont_ok && b_ap && state == ST_WRB;
  endsequence

  chk_mode_load: assert property (
    op == OP_MODE |=> mode == $past({cmd.bank_select, cmd.addr})
      && mode_loaded)
    else $error("mode register not loaded from command");
  chk_deselect_quiet: assert property (
    cmd.cs_n && state == ST_IDLE |=> $stable(mode) && state == ST_IDLE)
    else $error("deselected command took effect");
  chk_nop_quiet: assert property (
    !cmd.cs_n && cmd.ras_n && cmd.cas_n && cmd.we_n && state == ST_IDLE
      |=> state == ST_IDLE && !col_rd && !col_wr)
    else $error("no-operation started an access");
  chk_rd_rd_pre: assert property (
    s_ap_rd_busy ##0 (op == OP_RD && cmd.bank_select != b_bank)
      |=> precharge_start[$past(b_bank)])
    else $error("read did not start precharge of cut read bank");
  chk_rd_wr_pre: assert property (
    s_ap_rd_busy ##0 (op == OP_WR && cmd.bank_select != b_bank)
      |=> precharge_start[$past(b_bank)])
    else $error("write did not start precharge of cut read bank");
  chk_wr_rd_recov: assert property (
    s_ap_wr_busy ##0 (op == OP_RD && cmd.bank_select != b_bank)
      |=> rec_cnt[$past(b_bank)] == REC_FULL)
    else $error("read did not start write recovery");
  chk_wr_wr_recov: assert property (
    s_ap_wr_busy ##0 (op == OP_WR && cmd.bank_select != b_bank)
      |=> rec_cnt[$past(b_bank)] == REC_FULL && col_wr)
    else $error("write did not start write recovery");
  chk_burst_four: assert property (
    (op == OP_RD && mode.burst_length == BL_4) ##1 (op == OP_NONE)[*4]
      |=> !col_rd && $past(col_rd))
    else $error("four-word burst length wrong");
  chk_seq_order: assert property (
    col_cont && (!mode.burst_order_select || b_full)
      |-> col_addr == COL_W'($past(col_addr) + 8'h01))
    else $error("sequential column step wrong");
  chk_il_order: assert property (
    col_cont && mode.burst_order_select && !b_full
      |-> (col_addr ^ b_start) == b_idx[COL_W-1:0])
    else $error("interleaved column wrong");
  chk_cl_two: assert property (
    col_rd && mode.latency == CL_2 |=> rd_data_valid)
    else $error("latency two read data late");
  chk_cl_three: assert property (
    mode.latency == CL_3 && $past(mode.latency) == CL_3
      |-> rd_data_valid == $past(col_rd, 2))
    else $error("latency three read data timing wrong");
  chk_single_wr: assert property (
    (op == OP_WR && mode.write_burst_length_select) ##1 op == OP_NONE
      |=> !col_wr)
    else $error("single-word write burst ran on");
  chk_stop_ends: assert property (
    op == OP_STOP && state != ST_IDLE && !b_ap
      |=> state == ST_IDLE && !col_rd && !col_wr)
    else $error("burst stop did not end burst");
endmodule

// ---- verification/sdmb_host_model.sv ----
// sdmb_host_model: memory-controller side, drives commands and byte masks.
// assumes one bench process calls its tasks, each acting at a rising edge.
`timescale 1ns/100ps
module sdmb_host_model (
  input wire logic clk_sys,
  output sdmb_pkg::sdmb_cmd_t cmd,
  output logic [3:0] dqm
);
  import sdmb_pkg::*;
  localparam sdmb_cmd_t NOP = 17'h0E000;
  initial begin
    cmd = NOP;
    dqm = 4'h0;
  end
  // idle and wait cycles carry a no-operation
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      cmd <= NOP;
    end
  endtask
  task automatic send(input logic [2:0] op, input logic [1:0] bk,
                      input logic [10:0] a, input logic sel_n = 1'b0);
    @(posedge clk_sys);
    cmd <= {sel_n, op, bk, a};
  endtask
  // reserved and test bits forced to zero, one spare cycle after
  task automatic mode_set(input logic [12:0] v);
    send(CMD_MODE, 2'h0, {1'b0, v[9], 2'h0, v[6:0]});
    idle(1);
  endtask
  // mask change always rides on a no-operation cycle
  task automatic mask(input logic [3:0] v);
    @(posedge clk_sys);
    cmd <= NOP;
    dqm <= v;
  endtask
endmodule

// ---- verification/tb_sdram_mode_and_burst_control.sv ----
// tb_sdram_mode_and_burst_control: self-checking bench for sdmb_ctrl.
// assumes the host model for commands and an axi4-lite master task pair.
`timescale 1ns/100ps
module tb_sdram_mode_and_burst_control;
  import sdmb_pkg::*;
  localparam int WRC = 2;
  logic clk_sys;
  logic rst_b;
  sdmb_cmd_t cmd;
  logic [3:0] dqm;
  sdmb_axi_req_t axi_req;
  sdmb_axi_rsp_t axi_rsp;
  sdmb_mode_t mode;
  logic mode_loaded;
  logic [7:0] col_addr;
  logic [1:0] col_bank;
  logic col_rd;
  logic col_wr;
  logic rd_data_valid;
  logic [3:0] precharge_start;
  logic [3:0] wr_byte_en;
  logic [3:0] rd_byte_en;
  int n_mismatch;
  int tests_run;
  int cyc;
  int ticks;
  int scyc[$];
  logic [7:0] saddr[$];
  logic [1:0] sbank[$];
  int vcyc[$];
  int pcyc[$];
  int pbank[$];
  logic [3:0] wbe[$];
  logic [3:0] vbe[$];
  sdmb_host_model host_u (.clk_sys(clk_sys), .cmd(cmd), .dqm(dqm));
  sdmb_ctrl #(.WR_CYCLES(WRC)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b),
    .cmd(cmd), .dqm(dqm), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .mode(mode), .mode_loaded(mode_loaded), .col_addr(col_addr),
    .col_bank(col_bank), .col_rd(col_rd), .col_wr(col_wr),
    .wr_byte_en(wr_byte_en), .rd_data_valid(rd_data_valid),
    .rd_byte_en(rd_byte_en), .precharge_start(precharge_start));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // event log, sampled mid-cycle where outputs are settled
  always @(negedge clk_sys) begin
    if (col_rd === 1'b1 || col_wr === 1'b1) begin
      scyc.push_back(cyc);
      saddr.push_back(col_addr);
      sbank.push_back(col_bank);
    end
    if (col_wr === 1'b1) wbe.push_back(wr_byte_en);
    if (rd_data_valid === 1'b1) begin
      vcyc.push_back(cyc);
      vbe.push_back(rd_byte_en);
    end
    for (int b = 0; b < 4; b++) begin
      if (precharge_start[b] === 1'b1) begin
        pcyc.push_back(cyc);
        pbank.push_back(b);
      end
    end
    cyc = cyc + 1;
  end
  always @(posedge clk_sys) begin
    ticks++;
    if (ticks == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic clr();
    scyc.delete();
    saddr.delete();
    sbank.delete();
    vcyc.delete();
    pcyc.delete();
    pbank.delete();
    wbe.delete();
    vbe.delete();
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s seen %0h expected %0h", $time, what,
               seen, exp);
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] r);
    logic aw_t;
    logic w_t;
    logic b_t;
    @(posedge clk_sys);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= s;
    axi_req.bready <= 1'b1;
    do begin
      @(negedge clk_sys);
      aw_t = axi_req.awvalid && axi_rsp.awready;
      w_t = axi_req.wvalid && axi_rsp.wready;
      b_t = axi_rsp.bvalid;
      r = axi_rsp.bresp;
      @(posedge clk_sys);
      if (aw_t) axi_req.awvalid <= 1'b0;
      if (w_t) axi_req.wvalid <= 1'b0;
    end while (b_t !== 1'b1);
    axi_req.bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic a_t;
    logic got;
    @(posedge clk_sys);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    do begin
      @(negedge clk_sys);
      a_t = axi_req.arvalid && axi_rsp.arready;
      got = axi_rsp.rvalid;
      d = axi_rsp.rdata;
      r = axi_rsp.rresp;
      @(posedge clk_sys);
      if (a_t) axi_req.arvalid <= 1'b0;
    end while (got !== 1'b1);
    axi_req.rready <= 1'b0;
  endtask
  task automatic t_modes();
    logic [2:0] bls[5] = '{BL_1, BL_2, BL_4, BL_8, BL_8};
    logic bts[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [2:0] cls[5] = '{CL_2, CL_3, CL_2, CL_3, CL_2};
    logic [7:0] sts[5] = '{8'h10, 8'h11, 8'hFE, 8'h05, 8'hFC};
    logic [12:0] mv;
    int n;
    chk(mode_loaded, 1'b0, "loaded before set");
    for (int i = 0; i < 5; i++) begin
      mv = {6'h00, cls[i], bts[i], bls[i]};
      n = 1 << bls[i];
      host_u.mode_set(mv);
      host_u.idle(1);
      chk(mode, mv, "mode value");
      clr();
      host_u.send(CMD_RD, 2'h1, {3'h0, sts[i]});
      host_u.idle(14);
      chk(scyc.size(), n, "burst length");
      foreach (saddr[k])
        chk(saddr[k], (bts[i] ? (sts[i] ^ k) : (sts[i] + k)) & 32'hFF,
            "column order");
      chk(vcyc.size(), n, "read words");
      chk(vcyc[0] - scyc[0], cls[i] - 1, "read latency");
    end
    chk(mode_loaded, 1'b1, "loaded after set");
    host_u.mode_set({3'h0, 1'b1, 2'h0, CL_2, 1'b0, BL_4});
    clr();
    host_u.send(CMD_WR, 2'h0, 11'h040);
    host_u.idle(10);
    chk(scyc.size(), 1, "single-word write");
    $display("test modes done");
  endtask
  task automatic t_stop();
    host_u.mode_set({6'h00, CL_3, 1'b0, BL_FULL});
    clr();
    host_u.send(CMD_RD, 2'h0, 11'h0FE);
    host_u.idle(3);
    host_u.send(CMD_STOP, 2'h0, 11'h000);
    host_u.idle(10);
    chk(scyc.size(), 4, "stopped page burst");
    chk(saddr[2], 8'h00, "page wrap");
    chk(vcyc.size(), 4, "stopped read words");
    $display("test stop done");
  endtask
  task automatic t_select();
    logic [1:0] r;
    logic [31:0] d;
    logic [12:0] mv;
    mv = {6'h00, CL_2, 1'b0, BL_2};
    host_u.mode_set(mv);
    clr();
    host_u.send(CMD_RD, 2'h0, 11'h020, 1'b1);
    host_u.idle(8);
    chk(scyc.size(), 0, "deselected");
    axi_wr(REG_CTRL, 32'hFFFF_FFFE, 4'hF, r);
    chk(r, RESP_OK, "ctrl write");
    host_u.send(CMD_RD, 2'h0, 11'h020);
    host_u.idle(8);
    chk(scyc.size(), 0, "decoder off");
    axi_wr(REG_CTRL, 32'hFFFF_FFFF, 4'hF, r);
    host_u.send(CMD_RD, 2'h0, 11'h020);
    host_u.idle(8);
    chk(scyc.size(), 2, "decoder on");
    axi_wr(4'h3, 32'h0000_0000, 4'hE, r);
    chk(r, RESP_OK, "ctrl low lane off");
    axi_wr(4'hD, 32'h0000_0000, 4'hF, r);
    chk(r, RESP_SLVERR, "unmapped write");
    axi_wr(REG_RECOV, 32'hFFFF_FFFF, 4'h1, r);
    chk(r, RESP_OK, "recovery write");
    axi_rd(4'h1, d, r);
    chk(d, 32'h0000_0001, "ctrl kept");
    axi_rd(4'hA, d, r);
    chk(d, 32'h0000_0000, "no recovery pending");
    axi_rd(4'hC, d, r);
    chk(r, RESP_SLVERR, "unmapped resp");
    chk(d, 32'h0, "unmapped data");
    axi_rd(REG_STATUS, d, r);
    chk(d[12:0], mv, "status mode");
    $display("test select done");
  endtask
  task automatic t_cap();
    logic [2:0] fo[4] = '{CMD_RD, CMD_RD, CMD_WR, CMD_WR};
    logic [2:0] so[4] = '{CMD_RD, CMD_WR, CMD_RD, CMD_WR};
    int de[4] = '{0, 0, WRC, WRC};
    int f1;
    host_u.mode_set({6'h00, CL_2, 1'b0, BL_4});
    for (int i = 0; i < 4; i++) begin
      clr();
      f1 = -1;
      host_u.send(fo[i], 2'h0, 11'h400);
      if (so[i] == CMD_WR) host_u.mask(4'hF);
      else host_u.idle(1);
      host_u.idle(1);
      host_u.send(so[i], 2'h1, 11'h020);
      host_u.idle(12);
      host_u.mask(4'h0);
      foreach (sbank[k]) if (f1 < 0 && sbank[k] == 2'h1) f1 = scyc[k];
      chk(pcyc.size(), 1, "one precharge");
      chk(pbank[0], 0, "precharge bank");
      chk(pcyc[0] - f1, de[i], "precharge time");
      if (i == 1) chk(vbe[0], 4'hF, "read output open");
      if (i == 1) chk(vbe[2], 4'h0, "read output masked");
    end
    clr();
    host_u.send(CMD_WR, 2'h2, 11'h000);
    host_u.idle(1);
    host_u.mask(4'hF);
    repeat (WRC - 2) host_u.idle(1);
    host_u.send(CMD_PRE, 2'h2, 11'h000);
    host_u.idle(1);
    host_u.mask(4'h0);
    host_u.idle(6);
    chk(pcyc.size(), 1, "write cut precharge");
    chk(pcyc[0] - scyc[0], WRC + 1, "write cut time");
    chk(wbe[1], 4'hF, "last word stored");
    chk(wbe[2], 4'h0, "masked word");
    $display("test concurrent done");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    axi_req = '0;
    n_mismatch = 0;
    tests_run = 0;
    cyc = 0;
    ticks = 0;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    t_modes();
    t_stop();
    t_select();
    t_cap();
    tally_and_finish();
  end
endmodule
